// ===== cpwm_channel.sv
// one output channel: duty compare and pin drive
`timescale 1ns/10ps
`include "cpwm_regs.svh"
module cpwm_channel
  import cpwm_pkg::*;
#(
  parameter int DUTY_W = `CPWM_DUTY_W
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // timebase view
  input wire logic timerRun,
  input wire logic periodStart,
  input wire logic tick,
  input wire logic timerRestart,
  // commands for this channel
  input wire logic cfgCmd,
  input wire logic dutyCmd,
  input wire logic offCmd,
  input wire logic [DUTY_W-1:0] dutyIn,
  // pin
  output logic pinOut,
  output logic pinOe_n,
  output logic configured
);
  logic [DUTY_W-1:0] duty_r, duty_nxt;
  logic [DUTY_W-1:0] markCnt_r, markCnt_nxt;
  logic en_r, en_nxt;
  logic mark_r, mark_nxt;

  // next values for duty, mark counter, pin mode
  always_comb begin
    duty_nxt = duty_r;
    markCnt_nxt = markCnt_r;
    en_nxt = en_r;
    mark_nxt = mark_r;
    if (cfgCmd) begin
      duty_nxt = dutyIn;
      en_nxt = 1'b1; // pin becomes modulator output
      markCnt_nxt = '0;
      mark_nxt = 1'b0;
    end else if (offCmd) begin
      mark_nxt = 1'b0;
    end else begin
      if (dutyCmd && en_r)
        duty_nxt = dutyIn; // no timer restart here
      if (!timerRun || timerRestart) begin
        mark_nxt = 1'b0;
        markCnt_nxt = '0;
      end else if (periodStart && tick) begin
        // high at period start unless duty is zero
        mark_nxt = (duty_nxt != '0);
        markCnt_nxt = DUTY_W'(1);
      end else if (mark_r) begin
        // mark lasts duty system clocks
        if (markCnt_r >= duty_r)
          mark_nxt = 1'b0;
        else
          markCnt_nxt = markCnt_r + DUTY_W'(1);
      end
    end
  end

  // register channel state
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      duty_r <= `CPWM_DUTY_RST;
      markCnt_r <= '0;
      en_r <= 1'b0;
      mark_r <= 1'b0;
    end else if (clkEn) begin
      duty_r <= duty_nxt;
      markCnt_r <= markCnt_nxt;
      en_r <= en_nxt;
      mark_r <= mark_nxt;
    end
  end

  assign pinOut = mark_r;
  assign pinOe_n = ~en_r; // floating until configured
  assign configured = en_r;
endmodule

// ===== cpwm_gen.sv
// continuous pwm generator: shared timer and two channels
// Function
// - period lasts (period+1)*4 prescaled timebase ticks, period 0..255
// - output mark lasts duty system clocks, duty 0..1023
// - prescaler divides timebase by 1, 4, 16 or 64
// - waveform runs on its own until the next configure command
// - off request halts shared timer, stopping all channels on it
// - duty update of zero silences only that channel
// - channels on the shared timer share period, own duties
// - configure restarts the timebase counter
// - duty update changes duty without restarting the timer
// - output stops in nap, sleep or when execution ends
// - wide variant: a divide-by-one configure returns other channels to divide-by-one
// - shared timer is busy while servo function owns it
// - timing follows system clock; forced slow clock stops output
// - configure makes the pin a modulator output and starts timer
// - pins float after power-up until configured
`timescale 1ns/10ps
`include "cpwm_regs.svh"
module cpwm_gen
  import cpwm_pkg::*;
#(
  parameter int PERIOD_W = `CPWM_PERIOD_W,
  parameter int DUTY_W = `CPWM_DUTY_W,
  parameter int NCH = 2,
  parameter bit WIDE_VARIANT = 1'b1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // configure command
  input wire logic cfgStb,
  input wire logic [NCH-1:0] cfgSel,
  input wire logic [PERIOD_W-1:0] cfgPeriod,
  input wire logic [DUTY_W-1:0] cfgDuty,
  input wire logic [1:0] cfgPresc,
  // duty update command
  input wire logic dutyStb,
  input wire logic [NCH-1:0] dutySel,
  input wire logic [DUTY_W-1:0] dutyVal,
  // off command
  input wire logic offStb,
  // system conditions
  input wire logic lowPower,
  input wire logic progEnd,
  input wire logic servoBusy,
  input wire logic slowClock,
  // pins
  output logic [NCH-1:0] pwmOut,
  output logic [NCH-1:0] pwmOe_n,
  // status
  output logic timerRunning,
  output logic [1:0] prescStatus,
  output logic [NCH-1:0] chConfigured
);
  cpwm_state_t state_r, state_nxt;
  logic [PERIOD_W-1:0] period_r, period_nxt;
  logic [PERIOD_W+1:0] baseCnt_r, baseCnt_nxt;
  logic [5:0] preCnt_r, preCnt_nxt;
  cpwm_presc_t presc_r, presc_nxt;
  logic tick;
  logic periodStart;
  logic stopReq;
  logic cfgGo;
  logic offGo;

  // prescaler terminal count for each division
  function automatic logic [5:0] presc_last(input cpwm_presc_t p);
    case (p)
      prescale_div_one: presc_last = 6'h00;
      prescale_div_four: presc_last = 6'h03;
      prescale_div_sixteen: presc_last = 6'h0f;
      prescale_div_sixtyfour: presc_last = 6'h3f;
      default: presc_last = 6'h00;
    endcase
  endfunction

  // conditions that stop the generator
  assign stopReq = lowPower | progEnd | slowClock;
  assign cfgGo = cfgStb && !servoBusy && (cfgSel != '0);
  assign offGo = offStb ||
    (cfgGo && cfgPeriod == '0 && cfgDuty == '0);
  assign tick = (preCnt_r == presc_last(presc_r));
  assign periodStart = (baseCnt_r == '0);

  // timer state, period, prescale and base counter
  always_comb begin
    state_nxt = state_r;
    period_nxt = period_r;
    presc_nxt = presc_r;
    baseCnt_nxt = baseCnt_r;
    preCnt_nxt = preCnt_r;
    case (state_r)
      CPWM_IDLE, CPWM_HALT: begin
        baseCnt_nxt = '0;
        preCnt_nxt = '0;
      end
      CPWM_RUN: begin
        // free running until reconfigured
        if (tick) begin
          preCnt_nxt = '0;
          // (period+1)*4 ticks per period
          if (baseCnt_r == {period_r, 2'b11})
            baseCnt_nxt = '0;
          else
            baseCnt_nxt = baseCnt_r + (PERIOD_W+2)'(1);
        end else begin
          preCnt_nxt = preCnt_r + 6'h01;
        end
      end
      default: state_nxt = CPWM_IDLE;
    endcase
    if (offGo || stopReq) begin
      state_nxt = CPWM_HALT; // shared timer halts all channels
      baseCnt_nxt = '0;
      preCnt_nxt = '0;
    end else if (cfgGo) begin
      state_nxt = CPWM_RUN;
      period_nxt = cfgPeriod; // one period for all channels
      // configure resets shared prescale to requested one; narrow variant keeps it on a divide-by-one request
      presc_nxt = WIDE_VARIANT ? cpwm_presc_t'(cfgPresc) :
        ((cfgPresc != 2'h0) ? cpwm_presc_t'(cfgPresc) : presc_r);
      baseCnt_nxt = '0; // restart timebase
      preCnt_nxt = '0;
    end
  end

  // register timer state
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r <= CPWM_IDLE;
      period_r <= `CPWM_PERIOD_RST;
      presc_r <= cpwm_presc_t'(`CPWM_PRESC_RST);
      baseCnt_r <= '0;
      preCnt_r <= '0;
    end else if (clkEn) begin
      state_r <= state_nxt;
      period_r <= period_nxt;
      presc_r <= presc_nxt;
      baseCnt_r <= baseCnt_nxt;
      preCnt_r <= preCnt_nxt;
    end
  end

  // one channel per pin, all on the shared timer
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      cpwm_channel #(
        .DUTY_W(DUTY_W)
      ) u_ch (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .timerRun(state_r == CPWM_RUN),
        .periodStart(periodStart),
        .tick(tick),
        .timerRestart(cfgGo),
        .cfgCmd(cfgGo && cfgSel[gi] && !offGo && !stopReq),
        .dutyCmd(dutyStb && dutySel[gi]),
        .offCmd(offGo || stopReq),
        // only a selected channel takes the configure duty
        .dutyIn((cfgGo && cfgSel[gi]) ? cfgDuty : dutyVal),
        .pinOut(pwmOut[gi]),
        .pinOe_n(pwmOe_n[gi]),
        .configured(chConfigured[gi])
      );
    end
  endgenerate

  assign timerRunning = (state_r == CPWM_RUN);
  assign prescStatus = presc_r;
endmodule

// ===== cpwm_gen_asserts.sv
// checker for the continuous pwm generator
`timescale 1ns/10ps
module cpwm_gen_asserts #(
  parameter int NCH = 2
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // commands and conditions
  input wire logic cfgStb,
  input wire logic [NCH-1:0] cfgSel,
  input wire logic [7:0] cfgPeriod,
  input wire logic offStb,
  input wire logic servoBusy,
  input wire logic lowPower,
  input wire logic progEnd,
  input wire logic slowClock,
  // pins and status
  input wire logic [NCH-1:0] pwmOut,
  input wire logic [NCH-1:0] pwmOe_n,
  input wire logic timerRunning
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // any system condition that halts the timer
  wire stopAny = lowPower | progEnd | slowClock;
  wire cfgOk = cfgStb & clkEn & (|cfgSel) & ~servoBusy & ~offStb;
  // pins float and timer idles in reset
  a_reset_float: assert property (disable iff (1'b0)
    !rst_n |=> pwmOe_n == '1 && pwmOut == '0 && !timerRunning)
    else $error("pins not floating in reset");
  a_cfg_start: assert property (
    cfgOk && !stopAny && cfgPeriod != 8'h00 |=>
    timerRunning && (pwmOe_n & $past(cfgSel)) == '0)
    else $error("configure did not start the timer");
  a_off_halt: assert property (offStb && clkEn |=> !timerRunning)
    else $error("off did not halt the timer");
  a_stop_halt: assert property (stopAny && clkEn |=>
    !timerRunning && pwmOut == '0)
    else $error("output runs in low power");
  a_servo_block: assert property (
    cfgStb && servoBusy && !timerRunning |=> !timerRunning)
    else $error("configure taken while servo busy");
  a_clk_freeze: assert property (!clkEn |=>
    $stable(pwmOut) && $stable(timerRunning))
    else $error("state moved with clock enable low");
  a_oe_held: assert property (!pwmOe_n[0] |=> !pwmOe_n[0])
    else $error("pin released after configure");
  a_idle_low: assert property (!timerRunning |=> pwmOut == '0)
    else $error("output high with timer halted");
  a_mark_run: assert property ($rose(pwmOut[0]) |-> timerRunning)
    else $error("mark started without timer");
  // main scenarios
  c_restart: cover property (cfgStb && timerRunning);
  c_second: cover property ($rose(pwmOut[1]));
  c_off: cover property (offStb && timerRunning);
endmodule
bind cpwm_gen cpwm_gen_asserts #(.NCH(NCH)) chk (.*);

// ===== cpwm_gen_bench.sv
// self-checking bench for the continuous pwm generator
`timescale 1ns/10ps
module cpwm_gen_bench;
  import cpwm_pkg::*;
  logic sys_clk, rst_n, clkEn, cfgStb, dutyStb, offStb, servoBusy;
  logic timerRunning;
  logic [1:0] cfgSel, dutySel, cfgPresc, pwmOut, pwmOe_n, cfgd, lvl;
  logic [1:0] prescStatus;
  logic [7:0] cfgPeriod;
  logic [9:0] cfgDuty, dutyVal;
  logic [2:0] stopV;
  int err_total, compares, hi, per, p, d;
  cpwm_gen uut (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn),
    .cfgStb(cfgStb), .cfgSel(cfgSel), .cfgPeriod(cfgPeriod),
    .cfgDuty(cfgDuty), .cfgPresc(cfgPresc), .dutyStb(dutyStb),
    .dutySel(dutySel), .dutyVal(dutyVal), .offStb(offStb),
    .lowPower(stopV[0]), .progEnd(stopV[1]), .servoBusy(servoBusy),
    .slowClock(stopV[2]), .pwmOut(pwmOut), .pwmOe_n(pwmOe_n),
    .timerRunning(timerRunning), .prescStatus(prescStatus),
    .chConfigured(cfgd));
  cpwm_load ld [1:0] (.pinOut(pwmOut), .pinOe_n(pwmOe_n), .level(lvl));
  // clock and watchdog
  initial begin
    sys_clk = 0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    #1000000;
    err_total++;
    summarize();
  end
  // helpers
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %0d seen %0d", nm, exp, seen);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic cfg(logic [1:0] s, int pv, int dv, int pr);
    cfgSel = s;
    cfgPeriod = pv[7:0];
    cfgDuty = dv[9:0];
    cfgPresc = pr[1:0];
    cfgStb = 1;
    step(1);
    cfgStb = 0;
  endtask
  task automatic upd(logic [1:0] s, int dv);
    dutySel = s;
    dutyVal = dv[9:0];
    dutyStb = 1;
    step(1);
    dutyStb = 0;
  endtask
  // mark length and rise-to-rise span seen by the load
  task automatic measure(int ch);
    int n;
    n = 0;
    while (lvl[ch] !== 1'b0 && n < 30000) begin
      step(1);
      n++;
    end
    while (lvl[ch] !== 1'b1 && n < 30000) begin
      step(1);
      n++;
    end
    hi = 0;
    while (lvl[ch] === 1'b1 && hi < 30000) begin
      step(1);
      hi++;
    end
    per = hi;
    while (lvl[ch] !== 1'b1 && per < 30000) begin
      step(1);
      per++;
    end
  endtask
  function automatic int expPer(int pv, int pr);
    return (pv + 1) * 4 * (1 << (2 * pr));
  endfunction
  task automatic summarize();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // test sequence
  initial begin
    void'($urandom(84319));
    {rst_n, cfgStb, dutyStb, offStb, servoBusy, stopV} = '0;
    {cfgSel, dutySel, cfgPresc, cfgPeriod, cfgDuty, dutyVal} = '0;
    clkEn = 1;
    step(6);
    rst_n = 1;
    check("oe", pwmOe_n, 2'b11);
    servoBusy = 1;
    cfg(2'b01, 3, 4, 0);
    step(2);
    check("run", timerRunning, 0);
    servoBusy = 0;
    upd(2'b01, 5);
    step(2);
    check("cfgd", cfgd, 0);
    for (int pr = 0; pr < 4; pr++) begin
      p = 1 + $urandom % 20;
      d = 1 + $urandom % (4 * p);
      cfg(2'b01, p, d, pr);
      check("oe0", pwmOe_n[0], 0);
      check("presc", prescStatus, pr);
      measure(0);
      check("per", per, expPer(p, pr));
      if (pr == 0) check("hi", hi, d);
    end
    cfg(2'b11, 9, 12, 0);
    check("presc", prescStatus, 0);
    step(1);
    check("lvl", lvl, 2'b11);
    upd(2'b10, 30);
    clkEn = 0;
    step(5);
    clkEn = 1;
    measure(0);
    check("hi0", hi, 12);
    measure(1);
    check("hi1", hi, 30);
    check("per1", per, expPer(9, 0));
    upd(2'b10, 0);
    measure(0);
    check("hi0", hi, 12);
    check("lvl1", lvl[1], 0);
    offStb = 1;
    step(1);
    offStb = 0;
    step(1);
    check("run", timerRunning, 0);
    check("lvl", lvl, 0);
    for (int i = 0; i < 3; i++) begin
      cfg(2'b01, 9, 12, 0);
      stopV = 3'b001 << i;
      step(2);
      check("stop", timerRunning, 0);
      stopV = 0;
    end
    summarize();
  end
endmodule

// ===== cpwm_load.sv
// pin load: fet gate with pull-down resistor
`timescale 1ns/10ps
module cpwm_load (
  // pin from the generator
  input wire logic pinOut,
  input wire logic pinOe_n,
  // level seen by the gate
  output logic level
);
  // pull-down holds the gate low while the pin floats
  assign level = pinOe_n ? 1'b0 : pinOut;
endmodule

// ===== cpwm_pkg.sv
// types for the continuous pwm generator
`include "cpwm_regs.svh"
package cpwm_pkg;
  typedef enum logic [1:0] {
    prescale_div_one = 2'b00,
    prescale_div_four = 2'b01,
    prescale_div_sixteen = 2'b10,
    prescale_div_sixtyfour = 2'b11
  } cpwm_presc_t;
  typedef enum logic [1:0] {
    CPWM_IDLE = 2'b00,
    CPWM_RUN = 2'b01,
    CPWM_HALT = 2'b10
  } cpwm_state_t;
endpackage

// ===== cpwm_regs.svh
// constants for the continuous pwm generator
`ifndef CPWM_REGS_SVH
`define CPWM_REGS_SVH
`define CPWM_PERIOD_W 8
`define CPWM_DUTY_W 10
`define CPWM_BASE_TICKS 4
`define CPWM_PERIOD_RST 8'h00
`define CPWM_DUTY_RST 10'h000
`define CPWM_PRESC_RST 2'h0
`endif
